/* inc/csb_fifo_if.sv */
// Carrier between the bus controller and its request FIFO.
// Assumes one clock shared by both modports.
`default_nettype none
interface csb_fifo_if;
    import csb_pkg::*;
    logic                  in_valid;
    logic                  in_ready;
    logic [CSB_FIFO_W-1:0] in_data;
    logic                  out_valid;
    logic                  out_ready;
    logic [CSB_FIFO_W-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready,
                  output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready,
                  input in_ready, out_valid, out_data);
endinterface
`default_nettype wire

/* inc/csb_pkg.sv */
// Constants and types for the cache system-bus interface.
// Assumes one clock and a synchronous active-low reset.
// Functional notes
// - Coprocessor cycles ignored like local-bus cycles
// - Pending means cycle must go to system
// - Master mode follows next-address and hold
// - First piped goes to second or piped-idle, never to second piped
// - Slave mode conditioned by hold acknowledge
// - Slave enters hold state after reset
// - Slave with work goes idle, requests hold
// - Slave does not drive bus in idle
// - Acknowledge starts cycle; done returns to hold
// - Acknowledge dropped: finish, hold, withdraw request
// - Re-request only after acknowledge negated
// - Delay release: piped, split 16-bit, lock
// - Latch pulse captures address in any state
// - Latch enable only while owning the bus
// - Pulse early; hit never gets address strobe (code strobes write, uncached and locked hits)
// - Idle or piped-idle when nothing pending
// - Transceiver: write strobe, enable, direction
// - Writes latched, reads flow through
// - Enable early uncached, late on read miss
// - Address strobe in first and first-piped
`default_nettype none
package csb_pkg;
    localparam int CSB_ADDR_W   = 30;
    localparam int CSB_CYC_W    = 34;
    localparam int CSB_FIFO_W   = 34;
    localparam int CSB_FIFO_D   = 16;
    localparam int CSB_A_TOP    = 29;
    localparam int CSB_CYC_WR   = 33;
    localparam int CSB_CYC_MIO  = 32;
    localparam int CSB_CYC_DC   = 31;
    localparam int CSB_CYC_NC   = 30;
    localparam logic CSB_RST_LOW = 1'h0;

    typedef enum logic [2:0] {
        CSB_IDLE,
        CSB_HOLD,
        CSB_FIRST,
        CSB_SECOND,
        CSB_FIRST_PIPED,
        CSB_SECOND_PIPED,
        CSB_SECOND_PIPED_IDLE
    } csb_state_t;

    // Coprocessor space: memory/io low with top address bit high
    function automatic logic csb_is_copro(input logic mio,
                                          input logic a_top);
        return (!mio) && a_top;
    endfunction
endpackage
`default_nettype wire

/* sim/csb_sys_model.sv */
// System side model: bus controller ready/next-address and arbiter.
// Assumes the controller's strobe, miss and hold request are registered.
`default_nettype none
module csb_sys_model (
    input  wire logic       clock_in,
    input  wire logic       nrst_in,
    input  wire logic       strobe_n_in,
    input  wire logic       miss_n_in,
    input  wire logic       hold_req_in,
    input  wire logic       grant_en_in,
    input  wire logic       pipe_en_in,
    input  wire logic [3:0] wait_in,
    output logic            ready_n_out,
    output logic            next_addr_n_out,
    output logic            hold_ack_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int   pend;
    int   cnt;
    logic xw;
    always @(posedge clock_in) begin : bus_ctl
        int p;
        p = pend + (strobe_n_in ? 0 : 1);
        ready_n_out <= 1'b1;
        if (!nrst_in) begin
            p = 0;
            cnt <= 0;
            xw <= 1'b0;
            next_addr_n_out <= 1'b1;
        end else begin
            // Cycles strobed with miss asserted (reads or writes) get one extra wait state
            if (!strobe_n_in) begin
                xw <= !miss_n_in;
            end
            if (p > 0 && cnt >= int'(wait_in) + int'(xw)) begin
                ready_n_out <= 1'b0;
                p = p - 1;
                cnt <= 0;
            end else if (p > 0) begin
                cnt <= cnt + 1;
            end
            next_addr_n_out <= !(pipe_en_in && p > 0);
        end
        pend <= p;
    end
    // Grant only follows a live request with grant_en; dropped when either goes low
    always @(posedge clock_in) begin
        hold_ack_out <= nrst_in && hold_req_in && grant_en_in;
    end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the system-bus controller.
// Assumes csb_sys_model stands for the system side.
`default_nettype none
module tb_top
    import csb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic slave_mode_in = 1'b0;
    logic cpu_start_in = 1'b0;
    logic [CSB_ADDR_W-1:0] cpu_addr_in = '0;
    logic cpu_mio_in = 1'b1;
    logic cpu_wr_in = 1'b0;
    logic lbd_n = 1'b1;
    logic cpu_noncache_in = 1'b0;
    logic hit_valid_in = 1'b0;
    logic hit_in = 1'b0;
    logic hold_in = 1'b0;
    logic grant_en = 1'b1;
    logic pipe_en = 1'b0;
    logic [3:0] wait_n = 4'h0;
    wire logic ready_n, nxt_n, ack;
    logic req_ready_out, sys_hold_line_out, sys_hold_ack_line_out;
    logic addr_latch_pulse_out, addr_latch_out_enable_n_out;
    logic sys_addr_strobe_n_out, write_data_latch_strobe_out;
    logic data_xcvr_out_enable_n_out, data_xcvr_direction_out;
    logic miss_n_out, cycle_done_out;
    logic [CSB_ADDR_W-1:0] cur_addr_out;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int n_stb = 0;
    int n_done = 0;
    int n_pls = 0;
    int n_wst = 0;

    csb_ctrl dut_u (.clock_in(clock_in), .nrst_in(nrst_in),
        .slave_mode_in(slave_mode_in), .cpu_start_in(cpu_start_in),
        .cpu_addr_in(cpu_addr_in), .cpu_mio_in(cpu_mio_in),
        .cpu_dc_in(1'b1), .cpu_wr_in(cpu_wr_in),
        .local_bus_access_decode_n_in(lbd_n),
        .cpu_noncache_in(cpu_noncache_in), .cpu_split16_in(1'b0),
        .cpu_lock_in(1'b0), .hit_valid_in(hit_valid_in),
        .hit_in(hit_in), .sys_ready_n_in(ready_n),
        .sys_next_addr_request_n_in(nxt_n), .sys_hold_line_in(hold_in),
        .sys_hold_ack_line_in(ack), .req_ready_out(req_ready_out),
        .sys_hold_line_out(sys_hold_line_out),
        .sys_hold_ack_line_out(sys_hold_ack_line_out),
        .addr_latch_pulse_out(addr_latch_pulse_out),
        .addr_latch_out_enable_n_out(addr_latch_out_enable_n_out),
        .sys_addr_strobe_n_out(sys_addr_strobe_n_out),
        .write_data_latch_strobe_out(write_data_latch_strobe_out),
        .data_xcvr_out_enable_n_out(data_xcvr_out_enable_n_out),
        .data_xcvr_direction_out(data_xcvr_direction_out),
        .miss_n_out(miss_n_out), .sys_lock_n_out(),
        .cycle_done_out(cycle_done_out), .cur_addr_out(cur_addr_out));
    csb_sys_model sys_u (.clock_in(clock_in), .nrst_in(nrst_in),
        .strobe_n_in(sys_addr_strobe_n_out), .miss_n_in(miss_n_out),
        .hold_req_in(sys_hold_line_out), .grant_en_in(grant_en),
        .pipe_en_in(pipe_en), .wait_in(wait_n), .ready_n_out(ready_n),
        .next_addr_n_out(nxt_n), .hold_ack_out(ack));

    always #4 clock_in = ~clock_in;
    // Event counters; the design's outputs are registered
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        n_stb <= n_stb + int'(sys_addr_strobe_n_out === 1'b0);
        n_done <= n_done + int'(cycle_done_out === 1'b1);
        n_pls <= n_pls + int'(addr_latch_pulse_out === 1'b1);
        n_wst <= n_wst + int'(write_data_latch_strobe_out === 1'b1);
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("Compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_num(input string nm, input int e, input int g);
        compares++;
        if (g != e) begin
            err_count++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic do_reset(input logic sl);
        @(posedge clock_in);
        nrst_in <= 1'b0;
        slave_mode_in <= sl;
        repeat (2) @(posedge clock_in);
        nrst_in <= 1'b1;
        #1;
        chk_bit("hold_req", 1'b0, sys_hold_line_out);
        chk_bit("latch_oe_n", 1'b1, addr_latch_out_enable_n_out);
        chk_bit("strobe_n", 1'b1, sys_addr_strobe_n_out);
    endtask
    task automatic issue(input logic [CSB_ADDR_W-1:0] a,
                         input logic mio, wr, nc, hit, lb_n);
        @(posedge clock_in);
        cpu_start_in <= 1'b1;
        cpu_addr_in <= a;
        cpu_mio_in <= mio;
        cpu_wr_in <= wr;
        cpu_noncache_in <= nc;
        lbd_n <= lb_n;
        @(posedge clock_in);
        cpu_start_in <= 1'b0;
        hit_valid_in <= 1'b1;
        hit_in <= hit;
        @(posedge clock_in);
        hit_valid_in <= 1'b0;
    endtask
    task automatic until_is(input string nm, ref logic s, input logic v,
                            input int lim);
        int k;
        k = 0;
        #1;
        while (s !== v && k < lim) begin
            @(posedge clock_in);
            #1;
            k++;
        end
        chk_bit(nm, v, s);
    endtask
    task automatic wait_done(input int tgt);
        int k;
        for (k = 0; k < 200 && n_done < tgt; k++)
            @(posedge clock_in);
        #1;
        chk_num("done_count", tgt, n_done);
    endtask
    task automatic quiet(input int n);
        int s0;
        s0 = n_stb;
        repeat (n) @(posedge clock_in);
        #1;
        chk_num("strobe_count", s0, n_stb);
    endtask
    // Returns cycles from strobe to transceiver enable
    task automatic run_read(input logic nc, output int lat);
        int d0;
        d0 = n_done;
        issue(30'h0123_4567, 1'b1, 1'b0, nc, 1'b0, 1'b1);
        until_is("strobe_n", sys_addr_strobe_n_out, 1'b0, 4);
        chk_bit("miss_n", nc, miss_n_out);
        chk_bit("dir", 1'b0, data_xcvr_direction_out);
        chk_bit("latch_oe_n", 1'b0, addr_latch_out_enable_n_out);
        chk_num("cur_addr", 32'h0123_4567, int'(cur_addr_out));
        for (lat = 0; lat < 6 && data_xcvr_out_enable_n_out !== 1'b0;
             lat++) begin
            @(posedge clock_in);
            #1;
        end
        wait_done(d0 + 1);
    endtask
    task automatic t_reads();
        int l_nc;
        int l_ms;
        wait_n <= 4'h2;
        run_read(1'b1, l_nc);
        run_read(1'b0, l_ms);
        chk_num("oe_later_on_miss", 1, int'(l_ms > l_nc));
    endtask
    task automatic t_filtered();
        int p0;
        p0 = n_pls;
        issue(30'h0000_0040, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
        quiet(8);
        chk_num("latch_pulse", 1, int'(n_pls > p0));
        issue(30'h2000_0010, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
        quiet(8);
        issue(30'h0000_0080, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        quiet(8);
    endtask
    task automatic t_write();
        int w0;
        int d0;
        w0 = n_wst;
        d0 = n_done;
        issue(30'h0000_0100, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        until_is("strobe_n", sys_addr_strobe_n_out, 1'b0, 4);
        chk_bit("dir", 1'b1, data_xcvr_direction_out);
        wait_done(d0 + 1);
        chk_num("wr_latch", w0 + 1, n_wst);
    endtask
    task automatic t_master_hold();
        int d0;
        d0 = n_done;
        hold_in <= 1'b1;
        until_is("hold_ack", sys_hold_ack_line_out, 1'b1, 4);
        chk_bit("latch_oe_n", 1'b1, addr_latch_out_enable_n_out);
        issue(30'h0000_0200, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        quiet(8);
        hold_in <= 1'b0;
        wait_done(d0 + 1);
    endtask
    task automatic t_pipe();
        int d0;
        d0 = n_done;
        pipe_en <= 1'b1;
        wait_n <= 4'h1;
        issue(30'h0000_0300, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        issue(30'h0000_0304, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
        issue(30'h0000_0308, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        wait_done(d0 + 3);
        quiet(6);
        pipe_en <= 1'b0;
    endtask
    // Queue fills while the bus is held away, then drains
    task automatic t_fill();
        int acc;
        int d0;
        d0 = n_done;
        acc = 0;
        hold_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        #1;
        while (req_ready_out === 1'b1 && acc < 24) begin
            issue(30'h0000_0400, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
            acc++;
            @(posedge clock_in);
            #1;
        end
        chk_num("fifo_room", 1, int'(acc >= CSB_FIFO_D && acc < 24));
        hold_in <= 1'b0;
        wait_done(d0 + acc);
        chk_bit("req_ready", 1'b1, req_ready_out);
    endtask
    task automatic t_slave();
        int d0;
        do_reset(1'b1);
        d0 = n_done;
        grant_en <= 1'b0;
        issue(30'h0000_0500, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
        until_is("hold_req", sys_hold_line_out, 1'b1, 4);
        quiet(6);
        chk_bit("latch_oe_n", 1'b1, addr_latch_out_enable_n_out);
        grant_en <= 1'b1;
        wait_done(d0 + 1);
        until_is("hold_req", sys_hold_line_out, 1'b0, 6);
    endtask
    task automatic t_slave_drop();
        int d0;
        d0 = n_done;
        wait_n <= 4'h4;
        issue(30'h0000_0600, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        issue(30'h0000_0604, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        until_is("strobe_n", sys_addr_strobe_n_out, 1'b0, 8);
        grant_en <= 1'b0;
        until_is("hold_req", sys_hold_line_out, 1'b0, 12);
        chk_bit("done", 1'b1, cycle_done_out);
        until_is("hold_req", sys_hold_line_out, 1'b1, 6);
        grant_en <= 1'b1;
        wait_done(d0 + 2);
    endtask

    initial begin
        do_reset(1'b0);
        t_reads();
        t_filtered();
        t_write();
        t_master_hold();
        t_pipe();
        t_fill();
        t_slave();
        t_slave_drop();
        give_verdict();
    end
endmodule
`default_nettype wire

/* verilog/csb_ctrl.sv */
// System-side bus state machine of the cache controller.
// Assumes a processor-side front end that presents decoded cycles
// and hit/miss results; pins are synchronous to clock_in.
`default_nettype none
module csb_ctrl
    import csb_pkg::*;
(
    input  wire logic                  clock_in,
    input  wire logic                  nrst_in,
    input  wire logic                  slave_mode_in,
    input  wire logic                  cpu_start_in,
    input  wire logic [CSB_ADDR_W-1:0] cpu_addr_in,
    input  wire logic                  cpu_mio_in,
    input  wire logic                  cpu_dc_in,
    input  wire logic                  cpu_wr_in,
    input  wire logic                  local_bus_access_decode_n_in,
    input  wire logic                  cpu_noncache_in,
    input  wire logic                  cpu_split16_in,
    input  wire logic                  cpu_lock_in,
    input  wire logic                  hit_valid_in,
    input  wire logic                  hit_in,
    input  wire logic                  sys_ready_n_in,
    input  wire logic                  sys_next_addr_request_n_in,
    input  wire logic                  sys_hold_line_in,
    input  wire logic                  sys_hold_ack_line_in,
    output logic                       req_ready_out,
    output logic                       sys_hold_line_out,
    output logic                       sys_hold_ack_line_out,
    output logic                       addr_latch_pulse_out,
    output logic                       addr_latch_out_enable_n_out,
    output logic                       sys_addr_strobe_n_out,
    output logic                       write_data_latch_strobe_out,
    output logic                       data_xcvr_out_enable_n_out,
    output logic                       data_xcvr_direction_out,
    output logic                       miss_n_out,
    output logic                       sys_lock_n_out,
    output logic                       cycle_done_out,
    output logic [CSB_ADDR_W-1:0]      cur_addr_out
);
    csb_fifo_if   q_if ();
    csb_state_t   state;
    csb_state_t   next_state;
    logic         ignore_cycle;
    logic         pending;
    logic         owned;
    logic         hold_cond;
    logic         na_seen;
    logic         lock_held;
    logic         split_left;
    logic         cur_wr;
    logic         cur_nc;
    logic         ack_d;
    logic         done;
    logic         start_cyc;
    logic         nx_wr;
    logic         nx_nc;
    logic [CSB_CYC_W-1:0] head;

    csb_fifo #(
        .WIDTH (CSB_FIFO_W),
        .DEPTH (CSB_FIFO_D)
    ) u_fifo (
        .clock_in (clock_in),
        .nrst_in  (nrst_in),
        .port_if  (q_if)
    );

    // Coprocessor and local cycles never reach the system bus
    assign ignore_cycle = !local_bus_access_decode_n_in
                        || csb_is_copro(cpu_mio_in,
                                        cpu_addr_in[CSB_A_TOP]);
    // Hits are dropped; misses, uncached reads, writes, locks forward
    assign q_if.in_valid = hit_valid_in && !ignore_cycle
                         && (cpu_wr_in || !hit_in || cpu_noncache_in
                             || cpu_lock_in);
    assign q_if.in_data  = {cpu_wr_in, cpu_mio_in, cpu_dc_in,
                            cpu_noncache_in, cpu_addr_in};
    assign head    = q_if.out_data;
    assign pending = q_if.out_valid;
    assign nx_wr = q_if.out_ready ? head[CSB_CYC_WR] : cur_wr;
    assign nx_nc = q_if.out_ready ? head[CSB_CYC_NC] : cur_nc;
    assign done    = !sys_ready_n_in
                   && (state == CSB_SECOND || state == CSB_SECOND_PIPED);
    assign start_cyc = (next_state == CSB_FIRST
                        || next_state == CSB_FIRST_PIPED);
    assign q_if.out_ready = start_cyc && (state != CSB_FIRST)
                          && (state != CSB_FIRST_PIPED);
    // Split halves and locked runs keep the bus
    assign owned = lock_held || split_left || cpu_lock_in;
    // Slave keeps bus while acknowledged; master loses it on hold
    assign hold_cond = slave_mode_in ? !sys_hold_ack_line_in
                                     : sys_hold_line_in;

    always_comb begin
        next_state = state;
        case (state)
            CSB_HOLD: begin
                if (slave_mode_in) begin
                    // Wait for the old acknowledge to clear
                    if (pending && !sys_hold_ack_line_in) begin
                        next_state = CSB_IDLE;
                    end
                end else if (!sys_hold_line_in) begin
                    next_state = CSB_IDLE;
                end
            end
            CSB_IDLE: begin
                if (slave_mode_in) begin
                    if (sys_hold_ack_line_in && pending) begin
                        next_state = CSB_FIRST;
                    end else if (!pending) begin
                        next_state = CSB_HOLD;
                    end
                end else if (sys_hold_line_in && !owned) begin
                    next_state = CSB_HOLD;
                end else if (pending) begin
                    next_state = CSB_FIRST;
                end
                // Otherwise stay idle
            end
            CSB_FIRST: begin
                next_state = CSB_SECOND;
            end
            CSB_SECOND: begin
                if (done) begin
                    if (hold_cond && !owned) begin
                        next_state = CSB_HOLD;
                    end else if (na_seen && pending) begin
                        next_state = CSB_FIRST_PIPED;
                    end else if (na_seen) begin
                        next_state = CSB_SECOND_PIPED_IDLE;
                    end else if (pending) begin
                        next_state = CSB_FIRST;
                    end else begin
                        next_state = slave_mode_in ? CSB_HOLD
                                                   : CSB_IDLE;
                    end
                end else if (na_seen && pending && !hold_cond) begin
                    next_state = CSB_SECOND_PIPED;
                end
            end
            CSB_FIRST_PIPED: begin
                // No direct jump to second piped
                next_state = na_seen ? CSB_SECOND_PIPED_IDLE
                                     : CSB_SECOND;
            end
            CSB_SECOND_PIPED: begin
                // Committed pipelined cycle runs despite lost ack
                if (done) begin
                    next_state = CSB_FIRST_PIPED;
                end
            end
            CSB_SECOND_PIPED_IDLE: begin
                if (hold_cond && !owned) begin
                    next_state = CSB_HOLD;
                end else if (pending) begin
                    next_state = CSB_FIRST_PIPED;
                end
            end
            default: begin
                next_state = CSB_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (nrst_in == CSB_RST_LOW) begin
            state <= slave_mode_in ? CSB_HOLD : CSB_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock_in) begin
        if (nrst_in == CSB_RST_LOW) begin
            na_seen <= 1'h0;
        end else if (start_cyc || done) begin
            na_seen <= 1'h0;
        end else if (!sys_next_addr_request_n_in) begin
            na_seen <= 1'h1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (nrst_in == CSB_RST_LOW) begin
            lock_held  <= 1'h0;
            split_left <= 1'h0;
            ack_d      <= 1'h0;
        end else begin
            ack_d     <= sys_hold_ack_line_in;
            // Lock persists one clock past the processor lock
            lock_held <= cpu_lock_in;
            if (q_if.in_valid && cpu_split16_in) begin
                split_left <= 1'h1;
            end else if (done && !q_if.in_valid) begin
                split_left <= 1'h0;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (nrst_in == CSB_RST_LOW) begin
            cur_wr       <= 1'h0;
            cur_nc       <= 1'h0;
            cur_addr_out <= '0;
        end else if (q_if.out_ready) begin
            cur_wr       <= head[CSB_CYC_WR];
            cur_nc       <= head[CSB_CYC_NC];
            cur_addr_out <= head[CSB_ADDR_W-1:0];
        end
    end

    always_ff @(posedge clock_in) begin
        if (nrst_in == CSB_RST_LOW) begin
            req_ready_out               <= 1'h0;
            sys_hold_line_out           <= 1'h0;
            sys_hold_ack_line_out       <= 1'h0;
            addr_latch_pulse_out        <= 1'h0;
            addr_latch_out_enable_n_out <= 1'h1;
            sys_addr_strobe_n_out       <= 1'h1;
            write_data_latch_strobe_out <= 1'h0;
            data_xcvr_out_enable_n_out  <= 1'h1;
            data_xcvr_direction_out     <= 1'h0;
            miss_n_out                  <= 1'h1;
            sys_lock_n_out              <= 1'h1;
            cycle_done_out              <= 1'h0;
        end else begin
            req_ready_out  <= q_if.in_ready;
            cycle_done_out <= done;
            // Pulse before hit known; may latch while not owner
            addr_latch_pulse_out <= cpu_start_in;
            // Slave requests from idle on; holds through lock
            sys_hold_line_out <= slave_mode_in
                && (next_state != CSB_HOLD || owned);
            sys_hold_ack_line_out <= !slave_mode_in
                && next_state == CSB_HOLD;
            // Outputs only while owning, never in slave idle
            addr_latch_out_enable_n_out <= !(next_state != CSB_HOLD
                && !(slave_mode_in && next_state == CSB_IDLE));
            // Strobe only for real forwarded cycles
            sys_addr_strobe_n_out <= !(next_state == CSB_FIRST
                || next_state == CSB_FIRST_PIPED);
            // Writes held in the latch, reads pass through
            write_data_latch_strobe_out <= q_if.out_ready
                && head[CSB_CYC_WR];
            data_xcvr_direction_out <= nx_wr;
            // Uncached reads enable in first, misses in second
            data_xcvr_out_enable_n_out <= !(
                (next_state == CSB_FIRST && (nx_wr || nx_nc))
                || next_state == CSB_SECOND
                || next_state == CSB_SECOND_PIPED);
            // Lets a bus controller add a miss wait state
            miss_n_out <= !(start_cyc && !nx_nc);
            sys_lock_n_out <= !owned;
        end
    end

    property p_first_piped_path;
        @(posedge clock_in) disable iff (!nrst_in)
        state == CSB_FIRST_PIPED |=> state != CSB_SECOND_PIPED;
    endproperty
    a_first_piped_path: assert property (p_first_piped_path)
        else $error("first piped jumped to second piped");

    property p_slave_idle_float;
        @(posedge clock_in) disable iff (!nrst_in)
        (slave_mode_in && next_state == CSB_IDLE)
            |=> addr_latch_out_enable_n_out;
    endproperty
    a_slave_idle_float: assert property (p_slave_idle_float)
        else $error("slave drove bus while idle");

    property p_strobe_state;
        @(posedge clock_in) disable iff (!nrst_in)
        !sys_addr_strobe_n_out |->
            (state == CSB_FIRST || state == CSB_FIRST_PIPED);
    endproperty
    a_strobe_state: assert property (p_strobe_state)
        else $error("address strobe outside first states");

    property p_reenter_needs_nack;
        @(posedge clock_in) disable iff (!nrst_in)
        (slave_mode_in && state == CSB_HOLD && ack_d)
            |=> state == CSB_HOLD || !ack_d;
    endproperty
    a_reenter_needs_nack: assert property (p_reenter_needs_nack)
        else $error("left hold while acknowledge still high");

    property p_master_hold_ack;
        @(posedge clock_in) disable iff (!nrst_in)
        (!slave_mode_in && state == CSB_HOLD) |-> sys_hold_ack_line_out
            && addr_latch_out_enable_n_out;
    endproperty
    a_master_hold_ack: assert property (p_master_hold_ack)
        else $error("master hold without acknowledge");

    property p_owned_oe;
        @(posedge clock_in) disable iff (!nrst_in)
        !addr_latch_out_enable_n_out |-> state != CSB_HOLD;
    endproperty
    a_owned_oe: assert property (p_owned_oe)
        else $error("latch enabled while not owner");

    property p_piped_finish;
        @(posedge clock_in) disable iff (!nrst_in)
        (state == CSB_SECOND_PIPED && !done) |=>
            state == CSB_SECOND_PIPED || state == CSB_FIRST_PIPED;
    endproperty
    a_piped_finish: assert property (p_piped_finish)
        else $error("piped cycle abandoned");

    property p_first_to_second;
        @(posedge clock_in) disable iff (!nrst_in)
        state == CSB_FIRST |=> state == CSB_SECOND;
    endproperty
    a_first_to_second: assert property (p_first_to_second)
        else $error("first state not followed by second");
endmodule
`default_nettype wire

/* verilog/csb_fifo.sv */
// Parameterised FIFO holding forwarded processor cycles.
// Assumes one clock and synchronous active-low reset.
`default_nettype none
module csb_fifo
    import csb_pkg::*;
#(
    parameter int WIDTH = CSB_FIFO_W,
    parameter int DEPTH = CSB_FIFO_D
) (
    input  wire logic clock_in,
    input  wire logic nrst_in,
    csb_fifo_if.fifo  port_if
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             do_wr;
    logic             do_rd;

    assign port_if.in_ready  = (count != AW'(0) + (AW+1)'(DEPTH));
    assign port_if.out_valid = (count != '0);
    assign port_if.out_data  = mem[rd_ptr];
    assign do_wr = port_if.in_valid && port_if.in_ready;
    assign do_rd = port_if.out_valid && port_if.out_ready;

    always_ff @(posedge clock_in) begin
        if (do_wr) begin
            mem[wr_ptr] <= port_if.in_data;
        end
    end

    always_ff @(posedge clock_in) begin
        if (nrst_in == CSB_RST_LOW) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule
`default_nettype wire
